// ===== design/adc_ctrl_regs.svh
// Register indices, field positions, reset values and codes.
// What this block does
// R1: Gain field codes 0..4 give 1x..16x, 0xF gives half; 5..E reserved.
// R2: Scanning is active whenever scan count is nonzero.
// R3: First conversion uses positive selection plus scan offset.
// R4: While scanning, each completed conversion before the last channel increments the scan offset by one.
// R5: A scan covers scan count plus one inputs.
// R6: Software keeps the scanned range within the existing analog inputs.
// R7: Negative codes: pin0, pin1, internal ground, I/O ground; rest reserved.
// R8: Positive codes 0x00..0x09 are pins 0..9; 0x0A..0x17 reserved.
// R9: Positive codes 0x18..0x1C are internal sources; 0x1D..0x1F reserved.
// R10: Software sets sampling time suited to bandgap or temperature source.
// R11: Reserved bits read zero; software writes them as zero.
// R12: Window match event output is emitted only when its enable is set.
// R13: Result event output is emitted only when its enable is set.
// R14: Flush-restart enable makes events flush, then start a conversion.
// R15: Start enable makes incoming events start a new conversion; this block ignores start events that arrive while a conversion is busy.
// R16: Enable-clear and enable-set registers read one shared enable set.
// R17: Writing one to enable-clear clears that enable and its request.
// R18: Interrupt request asserts when any flag is set with its enable.
// R19: Writing one to enable-set sets that enable; zero leaves it.
// R20: Result flag sets on new result; cleared by write-one or result read.
// R21: Overrun flag sets when unread result is overwritten; write-one clears.
// R22: Window flag sets a cycle after match; write-one or result read clears.
// R23: After the last channel of a scan the offset returns to zero.
`ifndef ADC_CTRL_REGS_SVH
`define ADC_CTRL_REGS_SVH

`define INPUT_SEL_IDX    8'h10
`define EVENT_CTRL_IDX   8'h14
`define INT_EN_CLR_IDX   8'h16
`define INT_EN_SET_IDX   8'h17
`define INT_FLAG_IDX     8'h18
`define RESULT_IDX       8'h1A

`define POS_SEL_LSB      0
`define NEG_SEL_LSB      8
`define SCAN_COUNT_LSB   16
`define SCAN_OFFSET_LSB  20
`define GAIN_LSB         24
`define INPUT_SEL_MASK   32'h0FFF1F1F
`define EVENT_CTRL_MASK  8'h33
`define IRQ_MASK         8'h0F

`define EV_START_BIT     0
`define EV_FLUSH_BIT     1
`define EV_RESULT_BIT    4
`define EV_WINDOW_BIT    5

`define IRQ_RESULT_BIT   0
`define IRQ_OVERRUN_BIT  1
`define IRQ_WINDOW_BIT   2
`define IRQ_SYNC_BIT     3

`define INPUT_SEL_RESET  32'h00000000
`define EVENT_CTRL_RESET 8'h00
`define IRQ_RESET        8'h00

`endif

// ===== design/adc_ctrl_pkg.sv
// Types shared by the converter control block.
package adc_ctrl_pkg;

  typedef enum logic [2:0] {
    GAIN_1X   = 3'h0,
    GAIN_2X   = 3'h1,
    GAIN_4X   = 3'h2,
    GAIN_8X   = 3'h3,
    GAIN_16X  = 3'h4,
    half_gain = 3'h5,
    GAIN_RSVD = 3'h7
  } gain_e;

  typedef enum logic [2:0] {
    NEG_PIN0          = 3'h0,
    NEG_PIN1          = 3'h1,
    NEG_INTERNAL_GND  = 3'h2,
    io_ground_source  = 3'h3,
    NEG_RSVD          = 3'h7
  } neg_src_e;

  typedef enum logic [2:0] {
    POS_PIN                    = 3'h0,
    POS_TEMPERATURE            = 3'h1,
    POS_BANDGAP                = 3'h2,
    quarter_core_supply_source = 3'h3,
    quarter_io_supply_source   = 3'h4,
    POS_DAC                    = 3'h5,
    POS_RSVD                   = 3'h7
  } pos_src_e;

  // Selection handed to the analog front end.
  typedef struct packed {
    gain_e      gain;
    logic [4:0] pos_code;
    pos_src_e   pos_src;
    logic [3:0] pos_pin;
    neg_src_e   neg_src;
  } front_end_s;

  typedef enum logic [2:0] {
    CONV_IDLE  = 3'b001,
    CONV_FLUSH = 3'b010,
    CONV_BUSY  = 3'b100
  } conv_state_e;

endpackage : adc_ctrl_pkg

// ===== design/adc_input_scan_event_irq_ctrl.sv
// Converter input selection, pin scan, event routing and interrupt control.
`timescale 1ns/1ns
`include "adc_ctrl_regs.svh"

module adc_input_scan_event_irq_ctrl #(
  parameter int ADDR_W   = 8,
  parameter int RESULT_W = 16
) (
  // Clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  // AXI4-Lite write address, data and response
  input  wire logic [ADDR_W-1:0]        s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0]        s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  // Event network
  input  wire logic                     event_in,
  output logic                          result_event_out,
  output logic                          window_event_out,
  // Converter core
  input  wire logic                     conv_done,
  input  wire logic [RESULT_W-1:0]      conv_result,
  input  wire logic                     window_match,
  input  wire logic                     sync_done,
  output logic                          conv_start,
  output logic                          conv_flush,
  output adc_ctrl_pkg::front_end_s      front_end,
  // Interrupt request
  output logic                          irq
);

  initial begin
    if (ADDR_W < 8 || ADDR_W > 16) begin
      $error("ADDR_W must lie between 8 and 16");
    end
    if (RESULT_W < 1 || RESULT_W > 32) begin
      $error("RESULT_W must lie between 1 and 32");
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Decoding functions.

  function automatic adc_ctrl_pkg::gain_e gain_dec(input logic [3:0] code);
    case (code)
      4'h0:    gain_dec = adc_ctrl_pkg::GAIN_1X;
      4'h1:    gain_dec = adc_ctrl_pkg::GAIN_2X;
      4'h2:    gain_dec = adc_ctrl_pkg::GAIN_4X;
      4'h3:    gain_dec = adc_ctrl_pkg::GAIN_8X;
      4'h4:    gain_dec = adc_ctrl_pkg::GAIN_16X;
      4'hF:    gain_dec = adc_ctrl_pkg::half_gain;
      default: gain_dec = adc_ctrl_pkg::GAIN_RSVD;
    endcase
  endfunction : gain_dec

  function automatic adc_ctrl_pkg::pos_src_e pos_dec(input logic [4:0] code);
    if (code <= 5'h09) begin
      pos_dec = adc_ctrl_pkg::POS_PIN;
    end else if (code == 5'h18) begin
      pos_dec = adc_ctrl_pkg::POS_TEMPERATURE;
    end else if (code == 5'h19) begin
      pos_dec = adc_ctrl_pkg::POS_BANDGAP;
    end else if (code == 5'h1A) begin
      pos_dec = adc_ctrl_pkg::quarter_core_supply_source;
    end else if (code == 5'h1B) begin
      pos_dec = adc_ctrl_pkg::quarter_io_supply_source;
    end else if (code == 5'h1C) begin
      pos_dec = adc_ctrl_pkg::POS_DAC;
    end else begin
      pos_dec = adc_ctrl_pkg::POS_RSVD;
    end
  endfunction : pos_dec

  function automatic adc_ctrl_pkg::neg_src_e neg_dec(input logic [4:0] code);
    case (code)
      5'h00:   neg_dec = adc_ctrl_pkg::NEG_PIN0;
      5'h01:   neg_dec = adc_ctrl_pkg::NEG_PIN1;
      5'h02:   neg_dec = adc_ctrl_pkg::NEG_INTERNAL_GND;
      5'h03:   neg_dec = adc_ctrl_pkg::io_ground_source;
      default: neg_dec = adc_ctrl_pkg::NEG_RSVD;
    endcase
  endfunction : neg_dec

  //////////////////////////////////////////////////////////////////////////////
  // Registers.

  logic [31:0]         input_sel_r;
  logic [7:0]          event_ctrl_r;
  logic [7:0]          int_en_r;
  logic [7:0]          int_flag_r;
  logic [RESULT_W-1:0] result_r;
  logic                result_unread_r;
  logic                restart_r;
  adc_ctrl_pkg::conv_state_e state_r;

  wire [4:0] pos_base    = input_sel_r[`POS_SEL_LSB +: 5];
  wire [4:0] neg_code    = input_sel_r[`NEG_SEL_LSB +: 5];
  wire [3:0] scan_count  = input_sel_r[`SCAN_COUNT_LSB +: 4];
  wire [3:0] scan_offset = input_sel_r[`SCAN_OFFSET_LSB +: 4];
  wire [3:0] gain_code   = input_sel_r[`GAIN_LSB +: 4];

  wire scan_active = scan_count != 4'h0;                          // [R2]
  // The sum wraps in five bits; software keeps the range legal.
  wire [4:0] pos_code = pos_base + {1'b0, scan_offset};           // [R3] [R6]
  wire scan_last = scan_offset >= scan_count;                     // [R5]

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: one write and one read at a time.

  logic              aw_held_r;
  logic              w_held_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0]       wdata_r;
  logic [3:0]        wstrb_r;
  logic              bvalid_r;
  logic              rvalid_r;
  logic [31:0]       rdata_r;
  logic [1:0]        bresp_r;
  logic [1:0]        rresp_r;

  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready  = !w_held_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take  = s_axi_wvalid && s_axi_wready;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire wr_go   = aw_held_r && w_held_r;

  wire [ADDR_W-3:0] wr_word = awaddr_r[ADDR_W-1:2];
  wire [ADDR_W-3:0] rd_word = s_axi_araddr[ADDR_W-1:2];
  wire [7:0]  wr_idx = {wr_word[5:0], 2'b00};
  wire [7:0]  rd_idx = {rd_word[5:0], 2'b00};
  wire [1:0]  hi_w   = 2'(awaddr_r[ADDR_W-1:2] >> 6);
  wire [1:0]  hi_r   = 2'(s_axi_araddr[ADDR_W-1:2] >> 6);

  // Each register sits in its own word at four times its index.
  function automatic logic [7:0] reg_sel(input logic [7:0] idx);
    reg_sel = 8'({idx[5:0], 2'b00});
  endfunction : reg_sel

  wire wr_input  = wr_go && hi_w == 2'h0 && wr_idx == reg_sel(`INPUT_SEL_IDX);
  wire wr_event  = wr_go && hi_w == 2'h0 && wr_idx == reg_sel(`EVENT_CTRL_IDX);
  wire wr_enclr  = wr_go && hi_w == 2'h0 && wr_idx == reg_sel(`INT_EN_CLR_IDX);
  wire wr_enset  = wr_go && hi_w == 2'h0 && wr_idx == reg_sel(`INT_EN_SET_IDX);
  wire wr_flag   = wr_go && hi_w == 2'h0 && wr_idx == reg_sel(`INT_FLAG_IDX);
  wire wr_result = wr_go && hi_w == 2'h0 && wr_idx == reg_sel(`RESULT_IDX);
  wire wr_hit = wr_input || wr_event || wr_enclr || wr_enset || wr_flag
                || wr_result;

  wire rd_input  = hi_r == 2'h0 && rd_idx == reg_sel(`INPUT_SEL_IDX);
  wire rd_event  = hi_r == 2'h0 && rd_idx == reg_sel(`EVENT_CTRL_IDX);
  wire rd_enclr  = hi_r == 2'h0 && rd_idx == reg_sel(`INT_EN_CLR_IDX);
  wire rd_enset  = hi_r == 2'h0 && rd_idx == reg_sel(`INT_EN_SET_IDX);
  wire rd_flag   = hi_r == 2'h0 && rd_idx == reg_sel(`INT_FLAG_IDX);
  wire rd_result = hi_r == 2'h0 && rd_idx == reg_sel(`RESULT_IDX);
  wire result_read = ar_take && rd_result;

  wire [31:0] strb_mask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}},
                           {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  wire [7:0]  wbyte = wdata_r[7:0] & {8{wstrb_r[0]}};

  // Reserved bits read as zero because they are never stored.
  wire [31:0] rd_mux =
    rd_input  ? input_sel_r :                                     // [R11]
    rd_event  ? {24'h0, event_ctrl_r} :
    (rd_enclr || rd_enset) ? {24'h0, int_en_r} :                  // [R16]
    rd_flag   ? {24'h0, int_flag_r} :
    rd_result ? 32'(result_r) : 32'h0;
  wire rd_hit = rd_input || rd_event || rd_enclr || rd_enset || rd_flag
                || rd_result;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= 32'h0;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= 2'h0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0;
      rresp_r   <= 2'h0;
    end else begin
      if (aw_take) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= (wr_hit && !wr_result) ? 2'h0 : 2'h2;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
      if (ar_take) begin
        rvalid_r <= 1'b1;
        rdata_r  <= rd_mux;
        rresp_r  <= rd_hit ? 2'h0 : 2'h2;
      end else if (rvalid_r && s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Conversion sequencing and scan offset.

  wire start_ev = event_in && event_ctrl_r[`EV_START_BIT];        // [R15]
  wire flush_ev = event_in && event_ctrl_r[`EV_FLUSH_BIT];        // [R14]

  // A flush aborts whatever is in flight; the restart follows one cycle later.
  adc_ctrl_pkg::conv_state_e state_nxt;
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      adc_ctrl_pkg::CONV_IDLE: begin
        if (flush_ev) begin
          state_nxt = adc_ctrl_pkg::CONV_FLUSH;
        end else if (start_ev) begin
          state_nxt = adc_ctrl_pkg::CONV_BUSY;
        end
      end
      adc_ctrl_pkg::CONV_FLUSH: begin
        state_nxt = adc_ctrl_pkg::CONV_BUSY;                      // [R14]
      end
      adc_ctrl_pkg::CONV_BUSY: begin
        if (flush_ev) begin
          state_nxt = adc_ctrl_pkg::CONV_FLUSH;
        end else if (conv_done) begin
          state_nxt = adc_ctrl_pkg::CONV_IDLE;
        end
      end
      default: state_nxt = adc_ctrl_pkg::CONV_IDLE;
    endcase
  end

  assign conv_flush = state_r == adc_ctrl_pkg::CONV_FLUSH;
  // The restart waits for the cycle after the flush, so that the core
  // never sees a start and an abort in the same cycle.
  assign conv_start = (state_r == adc_ctrl_pkg::CONV_IDLE
                       && state_nxt == adc_ctrl_pkg::CONV_BUSY)  // [R15]
                      || restart_r;                               // [R14]
  wire done_ok = conv_done && state_r == adc_ctrl_pkg::CONV_BUSY && !flush_ev;

  wire [3:0] offset_nxt = !scan_active ? scan_offset :
                          scan_last ? 4'h0 :                      // [R23]
                          scan_offset + 4'h1;                     // [R4]

  wire [31:0] input_wr = (input_sel_r & ~strb_mask)
                         | (wdata_r & strb_mask & `INPUT_SEL_MASK);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r      <= adc_ctrl_pkg::CONV_IDLE;
      restart_r    <= 1'b0;
      input_sel_r  <= `INPUT_SEL_RESET;
      event_ctrl_r <= `EVENT_CTRL_RESET;
    end else begin
      state_r <= state_nxt;
      restart_r <= state_r == adc_ctrl_pkg::CONV_FLUSH;           // [R14]
      if (wr_input) begin
        input_sel_r <= input_wr;
      end else if (done_ok) begin
        input_sel_r[`SCAN_OFFSET_LSB +: 4] <= offset_nxt;         // [R4]
      end
      if (wr_event) begin
        event_ctrl_r <= wbyte & `EVENT_CTRL_MASK;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Result capture, flags, enables and events.

  wire [7:0] flag_set = {4'h0, sync_done, window_match,
                         done_ok && result_unread_r, done_ok};
  wire [7:0] flag_clr = (wr_flag ? wbyte : 8'h0)
                        | (result_read ? 8'h05 : 8'h0);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      int_en_r         <= `IRQ_RESET;
      int_flag_r       <= `IRQ_RESET;
      result_r         <= '0;
      result_unread_r  <= 1'b0;
      result_event_out <= 1'b0;
      window_event_out <= 1'b0;
    end else begin
      if (wr_enclr) begin
        int_en_r <= int_en_r & ~(wbyte & `IRQ_MASK);              // [R17]
      end else if (wr_enset) begin
        int_en_r <= int_en_r | (wbyte & `IRQ_MASK);               // [R19]
      end
      // Set wins over clear; window flag lands one cycle after the match.
      int_flag_r <= ((int_flag_r & ~flag_clr) | flag_set) // [R20] [R21] [R22]
                    & `IRQ_MASK;
      if (done_ok) begin
        result_r        <= conv_result;
        result_unread_r <= 1'b1;
      end else if (result_read) begin
        result_unread_r <= 1'b0;
      end
      result_event_out <= done_ok && event_ctrl_r[`EV_RESULT_BIT]; // [R13]
      window_event_out <= window_match
                          && event_ctrl_r[`EV_WINDOW_BIT];        // [R12]
    end
  end

  // Clearing an enable drops its request at once.
  assign irq = |(int_flag_r & int_en_r);                          // [R18] [R17]

  assign front_end.gain     = gain_dec(gain_code);                // [R1]
  assign front_end.pos_code = pos_code;
  assign front_end.pos_src  = pos_dec(pos_code);                  // [R8] [R9]
  assign front_end.pos_pin  = pos_code[3:0];                      // [R8]
  assign front_end.neg_src  = neg_dec(neg_code);                  // [R7]

endmodule : adc_input_scan_event_irq_ctrl

// ===== testbench/adc_ctrl_props.sv
// Port-level assertions for the converter control block.
`timescale 1ns/1ns
module adc_ctrl_props (
  // Clock and reset
  input wire logic                     ref_clk,
  input wire logic                     rst,
  // Watched ports
  input wire logic                     event_in,
  input wire logic                     conv_done,
  input wire logic                     window_match,
  input wire logic                     result_event_out,
  input wire logic                     window_event_out,
  input wire logic                     conv_start,
  input wire logic                     conv_flush,
  input wire adc_ctrl_pkg::front_end_s front_end
);
  logic [4:0] pc;
  logic       pin_c;
  logic       int_c;
  assign pc    = front_end.pos_code;
  assign pin_c = pc <= 5'h09;
  assign int_c = pc >= 5'h18 && pc <= 5'h1C;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // A flush aborts first and restarts on the following edge.
  sequence s_flush_start;
    conv_flush ##1 conv_start;
  endsequence
  AST_FLUSH_START: assert property (conv_flush |-> s_flush_start)
    else $error("flush not followed by a start");
  AST_FLUSH_CAUSE: assert property (conv_flush |-> $past(event_in))
    else $error("flush without an incoming event");
  AST_FLUSH_ONE: assert property (conv_flush |=> !conv_flush)
    else $error("flush longer than one cycle");
  AST_START_CAUSE: assert property (
    conv_start |-> event_in || $past(conv_flush))
    else $error("start without a cause");
  AST_RES_EVENT: assert property (
    result_event_out |-> $past(conv_done))
    else $error("result event without a finished conversion");
  AST_WIN_EVENT: assert property (
    window_event_out |-> $past(window_match))
    else $error("window event without a match");
  AST_POS_PIN: assert property (
    pin_c |-> front_end.pos_src == adc_ctrl_pkg::POS_PIN &&
    front_end.pos_pin == pc[3:0])
    else $error("pin code not routed to its pin");
  AST_POS_INT: assert property (
    int_c |-> front_end.pos_src == 3'(pc - 5'h17))
    else $error("internal source decoded wrongly");
  AST_POS_RSVD: assert property (
    !pin_c && !int_c |-> front_end.pos_src == adc_ctrl_pkg::POS_RSVD)
    else $error("reserved positive code not flagged");
endmodule : adc_ctrl_props

// ===== testbench/conv_core_model.sv
// Behavioural converter core that answers start and flush requests.
`timescale 1ns/1ns
module conv_core_model (
  // Clock and reset
  input wire logic                     ref_clk,
  input wire logic                     rst,
  // Requests from the control block
  input wire logic                     conv_start,
  input wire logic                     conv_flush,
  input wire adc_ctrl_pkg::front_end_s front_end,
  // Bench commands
  input wire logic                     win_hit,
  input wire logic                     sync_kick,
  input wire logic [3:0]               lat,
  // Answers
  output logic                         conv_done,
  output logic [15:0]                  conv_result,
  output logic                         window_match,
  output logic                         sync_done
);
  logic       busy_r;
  logic [3:0] cnt_r;
  logic [4:0] code_r;
  always @(posedge ref_clk) begin
    conv_done <= 1'b0;
    window_match <= 1'b0;
    sync_done <= sync_kick;
    // The result bus is only valid with done, so it churns otherwise.
    conv_result <= ~conv_result;
    if (rst) begin
      busy_r <= 1'b0;
      conv_result <= 16'h0000;
    end else if (conv_flush) begin
      busy_r <= 1'b0;
    end else if (conv_start) begin
      busy_r <= 1'b1;
      cnt_r <= lat;
      code_r <= front_end.pos_code;
    end else if (busy_r && cnt_r == 4'h0) begin
      busy_r <= 1'b0;
      conv_done <= 1'b1;
      window_match <= win_hit;
      conv_result <= {8'hA5, 3'h0, code_r};
    end else if (busy_r) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end
endmodule : conv_core_model

// ===== testbench/adc_input_scan_event_irq_ctrl_tb.sv
// Self-checking bench for the converter control block.
`timescale 1ns/1ns
module adc_input_scan_event_irq_ctrl_tb;
  typedef struct {
    logic [31:0] wd;
    logic [2:0]  g, ps, ns;
  } row_s;
  logic        ref_clk, rst, event_in, win_hit, sync_kick;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready;
  logic        s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, irq, conv_done, window_match, sync_done;
  logic        result_event_out, window_event_out, conv_start, conv_flush;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb, lat;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [15:0] conv_result;
  adc_ctrl_pkg::front_end_s front_end;
  int          bad_count = 0, n_tests = 0, n_rev = 0, n_wev = 0;
  int          n_st = 0, n_fl = 0;
  // Gain, positive source and negative source for each selection word.
  // Sampling time for the internal-source rows is set outside.
  row_s rows[10] = '{'{32'h00000000, 0, 0, 0}, '{32'h01000109, 1, 0, 1},
    '{32'h02000218, 2, 1, 2}, '{32'h03000319, 3, 2, 3},
    '{32'h0400041A, 4, 3, 7}, '{32'h0F001F1B, 5, 4, 7},
    '{32'h0500001C, 7, 5, 0}, '{32'h0E00000A, 7, 7, 0},
    '{32'h00000017, 0, 7, 0}, '{32'h0000001D, 0, 7, 0}};

  adc_input_scan_event_irq_ctrl i_dut (.ref_clk, .rst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .event_in,
    .result_event_out, .window_event_out, .conv_done, .conv_result,
    .window_match, .sync_done, .conv_start, .conv_flush, .front_end, .irq);
  conv_core_model i_core (.ref_clk, .rst, .conv_start, .conv_flush,
    .front_end, .win_hit, .sync_kick, .lat, .conv_done, .conv_result,
    .window_match, .sync_done);

  always @(posedge ref_clk) begin
    n_rev <= n_rev + int'(result_event_out === 1'b1);
    n_wev <= n_wev + int'(window_event_out === 1'b1);
    n_st <= n_st + int'(conv_start === 1'b1);
    n_fl <= n_fl + int'(conv_flush === 1'b1);
  end

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  //////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  task automatic hang;
    bad_count++;
    $display("Error %0t: wait ran out", $time);
    tally_and_finish();
  endtask : hang

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge ref_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
    // One idle edge keeps a release apart from the next request.
    @(posedge ref_clk);
    if (k == 40) hang();
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    int k;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge ref_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    @(posedge ref_clk);
    if (k == 40) hang();
    chk(rd, exp);
  endtask : rdc

  // One event pulse; a conversion that does not come is fine unless wanted.
  task automatic trig(input bit want);
    int k;
    event_in <= 1'b1;
    @(posedge ref_clk);
    event_in <= 1'b0;
    for (k = 0; k < 20 && conv_done !== 1'b1; k++) @(posedge ref_clk);
    repeat (2) @(posedge ref_clk);
    if (want && k == 20) hang();
  endtask : trig

  initial begin
    rst = 1'b1;
    {event_in, win_hit, sync_kick, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    lat = 4'h3;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    foreach (rows[i]) rdc(8'h40 + 8'(i) * 8'h08, 32'h0);
    foreach (rows[i]) begin
      wr(8'h40, rows[i].wd);
      chk(front_end.gain, rows[i].g);
      chk(front_end.pos_src, rows[i].ps);
      chk(front_end.neg_src, rows[i].ns);
      chk(front_end.pos_code, rows[i].wd[4:0]);
      if (rows[i].ps == 3'h0) chk(front_end.pos_pin, rows[i].wd[3:0]);
    end
    wr(8'h40, 32'hFFFFFFFF);
    rdc(8'h40, 32'h0FFF1F1F);
    wr(8'h50, 32'hFF);
    rdc(8'h50, 32'h33);
    wr(8'h5C, 32'hFF);
    rdc(8'h58, 32'h0F);
    wr(8'h58, 32'h05);
    wr(8'h58, 32'h00);
    rdc(8'h5C, 32'h0A);
    rdc(8'h7C, 32'h0);
    chk(rsp, 2'h2);
    wr(8'h68, 32'h1234);
    chk(rsp, 2'h2);
    wr(8'h58, 32'h0F);
    wr(8'h5C, 32'h01);
    wr(8'h50, 32'h11);
    // Base 2 and three channels stay inside the pin range.
    wr(8'h40, 32'h00020002);
    for (int i = 0; i < 4; i++) begin
      chk(front_end.pos_code, 2 + i % 3);
      trig(1);
      chk(n_rev, i + 1);
    end
    rdc(8'h40, 32'h00120002);
    rdc(8'h60, 32'h03);
    chk(irq, 1'b1);
    rdc(8'h68, 32'h0000A502);
    rdc(8'h60, 32'h02);
    chk(irq, 1'b0);
    wr(8'h60, 32'h02);
    rdc(8'h60, 32'h00);
    wr(8'h50, 32'h01);
    wr(8'h40, 32'h00100004);
    chk(front_end.pos_code, 5'h05);
    trig(1);
    chk(front_end.pos_code, 5'h05);
    chk(n_rev, 4);
    wr(8'h60, 32'h0F);
    wr(8'h5C, 32'h04);
    wr(8'h50, 32'h21);
    win_hit <= 1'b1;
    trig(1);
    chk(n_wev, 1);
    rdc(8'h60, 32'h07);
    chk(irq, 1'b1);
    rdc(8'h68, 32'h0000A505);
    rdc(8'h60, 32'h02);
    wr(8'h50, 32'h01);
    lat <= 4'h0;
    trig(1);
    win_hit <= 1'b0;
    chk(n_wev, 1);
    wr(8'h50, 32'h02);
    trig(1);
    chk(n_fl, 1);
    chk(n_st, 8);
    wr(8'h50, 32'h00);
    trig(0);
    chk(n_st, 8);
    chk(n_fl, 1);
    wr(8'h60, 32'h0F);
    wr(8'h5C, 32'h08);
    sync_kick <= 1'b1;
    @(posedge ref_clk);
    sync_kick <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rdc(8'h60, 32'h08);
    chk(irq, 1'b1);
    wr(8'h58, 32'h08);
    chk(irq, 1'b0);
    tally_and_finish();
  end
endmodule : adc_input_scan_event_irq_ctrl_tb

bind adc_input_scan_event_irq_ctrl adc_ctrl_props i_props (.ref_clk, .rst,
  .event_in, .conv_done, .window_match, .result_event_out,
  .window_event_out, .conv_start, .conv_flush, .front_end);
